// >>> verilog/led_pkg.sv
package led_pkg;
   // Clock rate and LED carrier timing.
   localparam int unsigned CLK_HZ           = 250_000_000;
   localparam int unsigned CARRIER_HZ       = 1_000;
   localparam int unsigned CARRIER_CYC      = CLK_HZ / CARRIER_HZ;
   localparam int unsigned DUTY_SINGLE_PCT  = 90;
   localparam int unsigned DUTY_DUAL_PCT    = 92;
   localparam int unsigned SINGLE_HIGH_CYC  = CARRIER_CYC * DUTY_SINGLE_PCT / 100;
   localparam int unsigned DUAL_HIGH_CYC    = CARRIER_CYC * DUTY_DUAL_PCT / 100;
   // Blink intervals in milliseconds, counted in carrier periods.
   localparam int unsigned SLOW_ON_MS       = 1000;
   localparam int unsigned SLOW_OFF_MS      = 200;
   localparam int unsigned FAST_ON_MS       = 400;
   localparam int unsigned FAST_OFF_MS      = 100;
   localparam int unsigned ERR_ON_MS        = 500;
   localparam int unsigned ERR_OFF_MS       = 500;
   localparam int unsigned MS_PER_PERIOD    = 1000 / CARRIER_HZ;
   localparam int unsigned SLOW_ON_PER      = SLOW_ON_MS / MS_PER_PERIOD;
   localparam int unsigned SLOW_OFF_PER     = SLOW_OFF_MS / MS_PER_PERIOD;
   localparam int unsigned FAST_ON_PER      = FAST_ON_MS / MS_PER_PERIOD;
   localparam int unsigned FAST_OFF_PER     = FAST_OFF_MS / MS_PER_PERIOD;
   localparam int unsigned ERR_ON_PER       = ERR_ON_MS / MS_PER_PERIOD;
   localparam int unsigned ERR_OFF_PER      = ERR_OFF_MS / MS_PER_PERIOD;

   // Displayed pattern, one-hot.
   typedef enum logic [5:0] {
      SHOW_OFF       = 6'b00_0001,
      SHOW_SLOW_GRN  = 6'b00_0010,
      SHOW_FAST_GRN  = 6'b00_0100,
      SHOW_GREEN     = 6'b00_1000,
      SHOW_AMBER_BLK = 6'b01_0000,
      SHOW_RED       = 6'b10_0000
   } show_e;

   // Colour at the pins.
   typedef enum logic [1:0] {
      COL_OFF    = 2'h0,
      COL_GREEN  = 2'h1,
      COL_RED    = 2'h2,
      COL_YELLOW = 2'h3
   } colour_e;
endpackage : led_pkg

// >>> verilog/led_pwm.sv
`timescale 1ns/1ps
`default_nettype none
// Free-running carrier counter with two duty comparisons.
module led_pwm
   import led_pkg::*;
#(
   parameter int unsigned PERIOD  = CARRIER_CYC,
   parameter int unsigned HIGH_A  = SINGLE_HIGH_CYC,
   parameter int unsigned HIGH_B  = DUAL_HIGH_CYC
) (
   input  wire logic clk,
   input  wire logic rst,
   output logic      phase_a,
   output logic      phase_b,
   output logic      wrap
);
   localparam int W = $clog2(PERIOD);
   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   initial begin
      if (PERIOD < 2 || HIGH_A >= PERIOD || HIGH_B >= PERIOD || HIGH_A == 0 || HIGH_B == 0) begin
         $error("led_pwm: duty thresholds must lie inside the period");
      end
   end

   // Count one carrier period and wrap.
   always_comb begin
      next_cnt = (cnt == W'(PERIOD - 1)) ? '0 : cnt + W'(1);
   end

   // Restart from zero on reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // High phase while below the threshold.
   assign phase_a = (cnt < W'(HIGH_A));
   assign phase_b = (cnt < W'(HIGH_B));
   assign wrap    = (cnt == W'(PERIOD - 1));
endmodule : led_pwm
`default_nettype wire

// >>> verilog/charger_led_driver.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - Green: minus line held low, plus line 1 kHz at 90 percent.
// R2 - Red: minus line 1 kHz at 90 percent, plus line held low.
// R3 - Yellow: plus line 1 kHz at 92 percent, minus line its inverse.
// R4 - Charging blinks green 1 s/0.2 s at low charge, 0.4 s/0.1 s at high.
// R5 - No mains off, complete solid green, error amber 0.5/0.5 s, fault solid red.
// R6 - Inhibit tied to battery positive unless charge output may be active.
// R7 - Inhibit stays tied to battery positive in fault, even with mains.
// R8 - AC relay energised while mains voltage is in range, else released.
// R9 - Carrier, duty and blink timing counted from the clock, restarted on reset.
module charger_led_driver
   import led_pkg::*;
#(
   parameter int unsigned CARRIER_PERIOD = CARRIER_CYC
) (
   input  wire logic MCLK,
   input  wire logic SYS_RST,
   input  wire logic AC_IN_RANGE,
   input  wire logic CHARGING,
   input  wire logic HIGH_SOC,
   input  wire logic CHARGE_DONE,
   input  wire logic ERROR,
   input  wire logic FAULT,
   output logic      LED_PLUS,
   output logic      LED_MINUS,
   output logic      VEHICLE_INHIBIT_OUTPUT,
   output logic      AC_RELAY
);
   localparam int BW = $clog2(SLOW_ON_PER + SLOW_OFF_PER + 1);
   localparam int unsigned HIGH_SINGLE = CARRIER_PERIOD * DUTY_SINGLE_PCT / 100;
   localparam int unsigned HIGH_DUAL   = CARRIER_PERIOD * DUTY_DUAL_PCT / 100;

   // Below 100 cycles a carrier cannot hold whole-percent duties with a low phase.
   initial begin
      if (CARRIER_PERIOD < 100) begin
         $error("charger_led_driver: carrier period must be at least 100 cycles");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   logic [5:0] sync1;
   logic [5:0] sync2;

   // Two flops per status pin before any logic looks at it.
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end else begin
         sync1 <= {FAULT, ERROR, CHARGE_DONE, HIGH_SOC, CHARGING, AC_IN_RANGE};
         sync2 <= sync1;
      end
   end

   logic ac_ok;
   logic chg;
   logic soc_hi;
   logic done;
   logic err;
   logic flt;
   assign {flt, err, done, soc_hi, chg, ac_ok} = sync2;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier.
   logic ph90;
   logic ph92;
   logic wrap;

   led_pwm #(
      .PERIOD (CARRIER_PERIOD),
      .HIGH_A (HIGH_SINGLE),
      .HIGH_B (HIGH_DUAL)
   ) u_pwm (
      .clk     (MCLK),
      .rst     (SYS_RST),
      .phase_a (ph90),
      .phase_b (ph92),
      .wrap    (wrap)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status selection, mains first, then fault.
   show_e show;
   show_e next_show;

   // Pick the pattern; fault beats error, error beats charging.
   always_comb begin
      if (!ac_ok) begin
         next_show = SHOW_OFF; // R5
      end else if (flt) begin
         next_show = SHOW_RED; // R5
      end else if (err) begin
         next_show = SHOW_AMBER_BLK; // R5
      end else if (chg) begin
         next_show = soc_hi ? SHOW_FAST_GRN : SHOW_SLOW_GRN; // R4
      end else if (done) begin
         next_show = SHOW_GREEN; // R5
      end else begin
         next_show = SHOW_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Blink timing in carrier periods.
   logic [BW-1:0] bcnt;
   logic [BW-1:0] next_bcnt;
   logic [BW-1:0] on_len;
   logic [BW-1:0] off_len;
   logic          lit;

   // On and off lengths for the current pattern.
   always_comb begin
      case (show)
         SHOW_SLOW_GRN: begin
            on_len  = BW'(SLOW_ON_PER); // R4
            off_len = BW'(SLOW_OFF_PER); // R4
         end
         SHOW_FAST_GRN: begin
            on_len  = BW'(FAST_ON_PER); // R4
            off_len = BW'(FAST_OFF_PER); // R4
         end
         SHOW_AMBER_BLK: begin
            on_len  = BW'(ERR_ON_PER); // R5
            off_len = BW'(ERR_OFF_PER); // R5
         end
         default: begin
            on_len  = BW'(1);
            off_len = '0;
         end
      endcase
   end

   // Restart the blink cycle on a pattern change, advance once per carrier.
   always_comb begin
      if (next_show != show) begin
         next_bcnt = '0; // R9
      end else if (!wrap) begin
         next_bcnt = bcnt;
      end else if (bcnt >= on_len + off_len - BW'(1)) begin
         next_bcnt = '0; // R9
      end else begin
         next_bcnt = bcnt + BW'(1);
      end
   end

   // Steady patterns stay lit; blinking ones light for the on part.
   assign lit = (off_len == '0) || (bcnt < on_len);

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         show <= SHOW_OFF;
         bcnt <= '0; // R9
      end else begin
         show <= next_show;
         bcnt <= next_bcnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Colour and pin drive.
   colour_e colour;
   logic    next_plus;
   logic    next_minus;
   logic    next_inhibit;
   logic    next_relay;

   // Map pattern to a colour, dark during the off part of a blink.
   always_comb begin
      case (show)
         SHOW_SLOW_GRN,
         SHOW_FAST_GRN,
         SHOW_GREEN:     colour = lit ? COL_GREEN : COL_OFF;
         SHOW_AMBER_BLK: colour = lit ? COL_YELLOW : COL_OFF;
         SHOW_RED:       colour = COL_RED;
         default:        colour = COL_OFF;
      endcase
   end

   // Drive the two lines and the interlocks.
   always_comb begin
      case (colour)
         COL_GREEN: begin
            next_plus  = ph90; // R1
            next_minus = 1'b0; // R1
         end
         COL_RED: begin
            next_plus  = 1'b0; // R2
            next_minus = ph90; // R2
         end
         COL_YELLOW: begin
            next_plus  = ph92; // R3
            next_minus = ~ph92; // R3
         end
         default: begin
            next_plus  = 1'b0;
            next_minus = 1'b0;
         end
      endcase
      next_inhibit = !(ac_ok && chg && !flt); // R6 R7
      next_relay   = ac_ok; // R8
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         LED_PLUS               <= 1'b0;
         LED_MINUS              <= 1'b0;
         VEHICLE_INHIBIT_OUTPUT <= 1'b1;
         AC_RELAY               <= 1'b0;
      end else begin
         LED_PLUS               <= next_plus;
         LED_MINUS              <= next_minus;
         VEHICLE_INHIBIT_OUTPUT <= next_inhibit;
         AC_RELAY               <= next_relay;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SYS_RST);

   property p_green_minus_low;
      (colour == COL_GREEN) |=> (LED_MINUS == 1'b0);
   endproperty
   a_green_minus_low: assert property (p_green_minus_low) // R1
      else $error("Green shows with minus line high.");

   property p_red_plus_low;
      (colour == COL_RED) |=> (LED_PLUS == 1'b0);
   endproperty
   a_red_plus_low: assert property (p_red_plus_low) // R2
      else $error("Red shows with plus line high.");

   property p_yellow_inverse;
      (colour == COL_YELLOW) |=> (LED_PLUS != LED_MINUS);
   endproperty
   a_yellow_inverse: assert property (p_yellow_inverse) // R3
      else $error("Yellow lines are not complementary.");

   property p_fault_red;
      (ac_ok && flt) |=> (show == SHOW_RED);
   endproperty
   a_fault_red: assert property (p_fault_red) // R5
      else $error("Fault does not select red.");

   property p_slow_select;
      (ac_ok && !flt && !err && chg && !soc_hi) |=> (show == SHOW_SLOW_GRN);
   endproperty
   a_slow_select: assert property (p_slow_select) // R4
      else $error("Low charge does not select slow blink.");

   property p_inhibit_fault;
      flt |-> ##1 VEHICLE_INHIBIT_OUTPUT;
   endproperty
   a_inhibit_fault: assert property (p_inhibit_fault) // R7
      else $error("Inhibit released during fault.");

   property p_inhibit_idle;
      !chg |=> VEHICLE_INHIBIT_OUTPUT;
   endproperty
   a_inhibit_idle: assert property (p_inhibit_idle) // R6
      else $error("Inhibit released while not charging.");

   property p_relay;
      ##1 (AC_RELAY == $past(ac_ok));
   endproperty
   a_relay: assert property (p_relay) // R8
      else $error("Relay does not follow mains.");

   property p_blink_wrap;
      (show == SHOW_SLOW_GRN && $stable(show)) |-> (bcnt < BW'(SLOW_ON_PER + SLOW_OFF_PER));
   endproperty
   a_blink_wrap: assert property (p_blink_wrap) // R9
      else $error("Blink counter ran past its cycle.");

   c_slow:   cover property (show == SHOW_SLOW_GRN ##1 !lit);
   c_amber:  cover property (colour == COL_YELLOW ##1 LED_PLUS);
   c_red:    cover property (show == SHOW_RED ##1 LED_MINUS);
   c_charge: cover property (chg && ac_ok ##2 !VEHICLE_INHIBIT_OUTPUT);
endmodule : charger_led_driver
`default_nettype wire

// >>> verif/led_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// Remote bi-colour lamp and vehicle inhibit input, judged from pin levels only.
module led_far_side
   import led_pkg::*;
(
   input  wire logic    led_plus,
   input  wire logic    led_minus,
   input  wire logic    inhibit,
   output var colour_e  seen,
   output var logic     blocked
);
   // Current flows one way per colour; equal levels leave the lamp dark.
   always_comb begin
      if (led_plus === 1'b1 && led_minus === 1'b0) begin
         seen = COL_GREEN;
      end else if (led_plus === 1'b0 && led_minus === 1'b1) begin
         seen = COL_RED;
      end else begin
         seen = COL_OFF;
      end
   end

   // A high inhibit line holds the vehicle still.
   always_comb begin
      blocked = (inhibit === 1'b1);
   end
endmodule // led_far_side
`default_nettype wire

// >>> verif/charger_led_driver_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module charger_led_driver_tb_top
   import led_pkg::*;
;
   logic    mclk = 1'b0;
   logic    rst  = 1'b1;
   logic    ac, chg, soc, done, err, flt;
   logic    plus, minus, inh, rly, blocked;
   colour_e seen;
   int      fails = 0;
   int      cmp_count = 0;

   ////////////////////////////////////////////////////////////////////////////
   // The clock toggles every 2 ns, for a period of 4 ns.
   always #2 mclk = ~mclk;

   // A short carrier lets whole periods be counted quickly.
   localparam int unsigned TB_PERIOD = 100;
   localparam int unsigned TB_HIGH_A = TB_PERIOD * DUTY_SINGLE_PCT / 100;
   localparam int unsigned TB_HIGH_B = TB_PERIOD * DUTY_DUAL_PCT / 100;

   charger_led_driver #(.CARRIER_PERIOD(TB_PERIOD)) u_dut (.MCLK(mclk), .SYS_RST(rst),
      .AC_IN_RANGE(ac), .CHARGING(chg), .HIGH_SOC(soc), .CHARGE_DONE(done), .ERROR(err),
      .FAULT(flt), .LED_PLUS(plus), .LED_MINUS(minus), .VEHICLE_INHIBIT_OUTPUT(inh),
      .AC_RELAY(rly));
   led_far_side u_far (.led_plus(plus), .led_minus(minus), .inhibit(inh), .seen(seen),
      .blocked(blocked));

   ////////////////////////////////////////////////////////////////////////////
   // Drives one status set after the edge and waits past the input pipeline.
   task automatic apply(input logic [5:0] v);
      {ac, chg, soc, done, err, flt} = v;
      repeat (8) @(posedge mclk);
      #1;
   endtask

   // Counts green and red cycles at the lamp over one whole carrier, then the interlocks.
   task automatic expect_pins(input string nm, input int ng, input int nr, input logic i,
                              input logic r);
      int g;
      int d;
      g = 0;
      d = 0;
      repeat (TB_PERIOD) begin
         @(posedge mclk);
         #1;
         g += (seen === COL_GREEN) ? 1 : 0;
         d += (seen === COL_RED) ? 1 : 0;
      end
      `CHK({nm, " green"}, ng, g)
      `CHK({nm, " red"}, nr, d)
      `CHK({nm, " inhibit"}, i, blocked)
      `CHK({nm, " relay"}, r, rly)
      $display("test %s finished", nm);
   endtask

   // Holds reset two cycles; outputs must sit at their idle levels.
   task automatic t_reset(input string nm);
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      `CHK({nm, " colour"}, COL_OFF, seen)
      `CHK({nm, " inhibit"}, 1'b1, blocked)
      `CHK({nm, " relay"}, 1'b0, rly)
      $display("test %s finished", nm);
      rst = 1'b0;
   endtask

   // Every status is raised while mains is absent; the lamp stays dark.
   task automatic t_no_ac();
      apply(6'b01_1111);
      expect_pins("no_ac", 0, 0, 1'b1, 1'b0);
   endtask

   // Fault wins over charging and keeps the vehicle held with mains present.
   task automatic t_fault();
      apply(6'b11_0001);
      expect_pins("fault", 0, TB_HIGH_A, 1'b1, 1'b1);
   endtask

   // Error beats charging; amber opens on its on phase with complementary lines.
   task automatic t_error();
      apply(6'b11_0010);
      `CHK("amber lines", 1'b1, plus ^ minus)
      expect_pins("error", TB_HIGH_B, TB_PERIOD - TB_HIGH_B, 1'b0, 1'b1);
   endtask

   // Charging at both charge states shows green and frees the vehicle.
   task automatic t_charge();
      apply(6'b11_0000);
      expect_pins("charge_low", TB_HIGH_A, 0, 1'b0, 1'b1);
      apply(6'b11_1000);
      expect_pins("charge_high", TB_HIGH_A, 0, 1'b0, 1'b1);
   endtask

   // A finished charge is solid green, and idle mains leaves the lamp dark.
   task automatic t_done();
      apply(6'b10_0100);
      expect_pins("done", TB_HIGH_A, 0, 1'b1, 1'b1);
      apply(6'b10_0000);
      expect_pins("idle", 0, 0, 1'b1, 1'b1);
   endtask

   // After a reset in mid-charge the carrier restarts, so plus falls after the high count.
   task automatic t_restart();
      repeat (TB_HIGH_A) @(posedge mclk);
      #1;
      `CHK("restart last high", 1'b1, plus)
      @(posedge mclk);
      #1;
      `CHK("restart first low", 1'b0, plus)
      $display("test restart finished");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence, with a second reset in mid-run while charging.
   initial begin
      {ac, chg, soc, done, err, flt} = 6'b00_0000;
      #1;
      t_reset("reset");
      t_no_ac();
      t_fault();
      t_error();
      t_charge();
      t_done();
      apply(6'b11_0000);
      t_reset("rerun_reset");
      t_restart();
      stop_test();
   end

   // Cuts a hang short well past the thousand or so cycles the tests need.
   initial begin
      #80000;
      fails++;
      stop_test();
   end
endmodule // charger_led_driver_tb_top
`default_nettype wire
